// ### hiltmr_top.sv
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module hiltmr_top (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // monitors in the bus clock domain
   input wire logic [hiltmr_pkg::ERR_W-1:0] err_evt,
   input wire logic [hiltmr_pkg::CHN_W-1:0] chn_evt,
   // monitor pulses from a foreign clock domain
   input wire logic mon_clk,
   input wire logic mon_rst_n,
   input wire logic [hiltmr_pkg::ASYNC_W-1:0] err_evt_async,
   // avalon-mm slave
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // interrupt to host
   output logic irq
);
   localparam int EW = hiltmr_pkg::ERR_W;
   localparam int CW = hiltmr_pkg::CHN_W;
   localparam int AW = hiltmr_pkg::ASYNC_W;

   // ****************************************
   // internal signals
   // ****************************************
   hiltmr_pkg::hiltmr_evt_t evt_now;
   hiltmr_pkg::hiltmr_evt_t stat_now;
   hiltmr_pkg::hiltmr_evt_t mask_now;
   hiltmr_pkg::hiltmr_state_t state_reg;
   hiltmr_pkg::hiltmr_state_t state_next;
   logic [AW-1:0] async_pulse;
   logic err_pend;
   logic chn_pend;
   logic any_pend;
   logic [EW-1:0] err_clr;
   logic [CW-1:0] chn_clr;
   logic wr_go;
   logic rd_go;
   logic err_mask_we;
   logic chn_mask_we;
   logic tmo_we;
   logic flag_clr;
   logic [31:0] wmask;
   logic [31:0] lat_reg;
   logic [31:0] cnt_reg;
   logic [31:0] tmo_reg;
   logic ack_hit;
   logic tmo_hit;
   logic tmo_flag_reg;
   logic [31:0] rdata;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] be_mask(input logic [3:0] be);
      be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   // saturating step keeps a long wait from wrapping to a short latency
   function automatic logic [31:0] step(input logic [31:0] v);
      if (v == hiltmr_pkg::CNT_MAX) begin
         step = v;
      end else begin
         step = v + 32'h0000_0001;
      end
   endfunction

   // ****************************************
   // event capture
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < AW; g++) begin : g_cdc
         hiltmr_cdc u_cdc (
            .src_clk(mon_clk),
            .src_rst_n(mon_rst_n),
            .src_pulse(err_evt_async[g]),
            .dst_clk(sys_clk),
            .dst_rst_n(rst_n),
            .dst_pulse(async_pulse[g])
         );
      end
   endgenerate

   // foreign events fold into the low error bits
   always_comb begin
      evt_now.err = err_evt;
      evt_now.err[AW-1:0] = err_evt[AW-1:0] | async_pulse;
      evt_now.chn = chn_evt;
   end

   // ****************************************
   // bus handshake: every access answers one cycle after it starts
   // ****************************************
   // registered so the wait line comes straight from a flip-flop
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      end
   end

   assign wr_go = avs_write && !avs_waitrequest;
   assign rd_go = avs_read && avs_waitrequest;
   assign wmask = avs_writedata & be_mask(avs_byteenable);

   // ****************************************
   // write decode
   // ****************************************
   // only the register addressed at the answering edge sees a strobe
   always_comb begin
      err_clr = '0;
      chn_clr = '0;
      err_mask_we = 1'b0;
      chn_mask_we = 1'b0;
      ack_hit = 1'b0;
      tmo_we = 1'b0;
      flag_clr = 1'b0;
      if (wr_go) begin
         if (avs_address == hiltmr_pkg::ERR_STAT_OFF) begin
            err_clr = wmask[EW-1:0];
         end else if (avs_address == hiltmr_pkg::ERR_MASK_OFF) begin
            err_mask_we = 1'b1;
         end else if (avs_address == hiltmr_pkg::CHN_STAT_OFF) begin
            chn_clr = wmask[CW-1:0];
         end else if (avs_address == hiltmr_pkg::CHN_MASK_OFF) begin
            chn_mask_we = 1'b1;
         end else if (avs_address == hiltmr_pkg::ACK_OFF) begin
            ack_hit = wmask[0];
         end else if (avs_address == hiltmr_pkg::TMO_OFF) begin
            tmo_we = 1'b1;
         end else if (avs_address == hiltmr_pkg::CTL_STAT_OFF) begin
            flag_clr = wmask[0];
         end
      end
   end

   // ****************************************
   // sticky groups
   // ****************************************
   // two groups, each its own sticky register
   hiltmr_sticky #(.W(EW)) u_err (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .evt(evt_now.err),
      .clr(err_clr),
      .mask_we(err_mask_we),
      .mask_wdata(avs_writedata[EW-1:0]),
      .stat(stat_now.err),
      .mask(mask_now.err),
      .pend(err_pend)
   );

   hiltmr_sticky #(.W(CW)) u_chn (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .evt(evt_now.chn),
      .clr(chn_clr),
      .mask_we(chn_mask_we),
      .mask_wdata(avs_writedata[CW-1:0]),
      .stat(stat_now.chn),
      .mask(mask_now.chn),
      .pend(chn_pend)
   );

   assign any_pend = err_pend || chn_pend;

   // ****************************************
   // request cycle, response timer, timeout
   // ****************************************
   // zero timeout means hold the request without limit
   assign tmo_hit = (tmo_reg != hiltmr_pkg::ZERO_RST) &&
      (step(cnt_reg) >= tmo_reg);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         hiltmr_pkg::ST_IDLE: begin
            if (any_pend) begin
               state_next = hiltmr_pkg::ST_REQ;
            end
         end
         hiltmr_pkg::ST_REQ: begin
            if (ack_hit) begin
               state_next = hiltmr_pkg::ST_IDLE;
            end else if (tmo_hit) begin
               state_next = hiltmr_pkg::ST_WAIT;
            end
         end
         hiltmr_pkg::ST_WAIT: begin
            if (ack_hit) begin
               state_next = hiltmr_pkg::ST_IDLE;
            end
         end
         default: begin
            state_next = hiltmr_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_reg <= hiltmr_pkg::ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ****************************************
   // response timer and timeout
   // ****************************************
   // the count is frozen in idle so the last latency survives until posted
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cnt_reg <= hiltmr_pkg::ZERO_RST;
      end else if (state_reg == hiltmr_pkg::ST_IDLE) begin
         if (any_pend) begin
            cnt_reg <= hiltmr_pkg::ZERO_RST;
         end
      end else begin
         cnt_reg <= step(cnt_reg);
      end
   end

   // latency of the last finished cycle, posted when the next begins
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         lat_reg <= hiltmr_pkg::ZERO_RST;
      end else if (state_reg == hiltmr_pkg::ST_IDLE && any_pend) begin
         lat_reg <= cnt_reg;
      end
   end

   // a new limit applies from the next compare, even mid-request
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tmo_reg <= hiltmr_pkg::ZERO_RST;
      end else if (tmo_we) begin
         tmo_reg <= (tmo_reg & ~be_mask(avs_byteenable)) | wmask;
      end
   end

   // a timeout in the clear cycle wins so it is never lost
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tmo_flag_reg <= 1'b0;
      end else if (state_reg == hiltmr_pkg::ST_REQ && tmo_hit) begin
         tmo_flag_reg <= 1'b1;
      end else if (flag_clr) begin
         tmo_flag_reg <= 1'b0;
      end
   end

   // ****************************************
   // interrupt output
   // ****************************************
   // taken from the next state so irq rises on the edge that enters REQ
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= (state_next == hiltmr_pkg::ST_REQ);
      end
   end

   // ****************************************
   // read mux
   // ****************************************
   always_comb begin
      rdata = hiltmr_pkg::WORD_ZERO;
      if (avs_address == hiltmr_pkg::ERR_STAT_OFF) begin
         rdata[EW-1:0] = stat_now.err;
      end else if (avs_address == hiltmr_pkg::ERR_MASK_OFF) begin
         rdata[EW-1:0] = mask_now.err;
      end else if (avs_address == hiltmr_pkg::CHN_STAT_OFF) begin
         rdata[CW-1:0] = stat_now.chn;
      end else if (avs_address == hiltmr_pkg::CHN_MASK_OFF) begin
         rdata[CW-1:0] = mask_now.chn;
      end else if (avs_address == hiltmr_pkg::LAT_OFF) begin
         rdata = lat_reg;
      end else if (avs_address == hiltmr_pkg::TMO_OFF) begin
         rdata = tmo_reg;
      end else if (avs_address == hiltmr_pkg::CTL_STAT_OFF) begin
         rdata[0] = tmo_flag_reg;
         rdata[3:1] = state_reg;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         avs_readdata <= hiltmr_pkg::WORD_ZERO;
      end else if (rd_go) begin
         avs_readdata <= rdata;
      end
   end
endmodule
`default_nettype wire

// ### hiltmr_pkg.sv
package hiltmr_pkg;
   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [5:0] ERR_STAT_OFF = 6'h00;
   localparam logic [5:0] ERR_MASK_OFF = 6'h04;
   localparam logic [5:0] CHN_STAT_OFF = 6'h08;
   localparam logic [5:0] CHN_MASK_OFF = 6'h0C;
   localparam logic [5:0] ACK_OFF = 6'h10;
   localparam logic [5:0] LAT_OFF = 6'h14;
   localparam logic [5:0] TMO_OFF = 6'h18;
   localparam logic [5:0] CTL_STAT_OFF = 6'h1C;
   // ****************************************
   // widths and reset values
   // ****************************************
   localparam int ERR_W = 8;
   localparam int CHN_W = 8;
   localparam int ASYNC_W = 4;
   localparam logic [31:0] MASK_RST = 32'hFFFF_FFFF;
   localparam logic [31:0] ZERO_RST = 32'h0000_0000;
   localparam logic [31:0] CNT_MAX = 32'hFFFF_FFFF;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   typedef struct packed {
      logic [ERR_W-1:0] err;
      logic [CHN_W-1:0] chn;
   } hiltmr_evt_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_REQ = 3'b010,
      ST_WAIT = 3'b100
   } hiltmr_state_t;
endpackage

// ### hiltmr_cdc.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// toggle crossing: one pulse in, one pulse out
// ****************************************
module hiltmr_cdc (
   // source domain
   input wire logic src_clk,
   input wire logic src_rst_n,
   input wire logic src_pulse,
   // destination domain
   input wire logic dst_clk,
   input wire logic dst_rst_n,
   output logic dst_pulse
);
   logic tog_reg;
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   // a toggle survives any clock ratio as long as pulses are spaced
   always_ff @(posedge src_clk) begin
      if (!src_rst_n) begin
         tog_reg <= 1'b0;
      end else if (src_pulse) begin
         tog_reg <= ~tog_reg;
      end
   end

   always_ff @(posedge dst_clk) begin
      if (!dst_rst_n) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else begin
         s1_reg <= tog_reg;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   assign dst_pulse = s2_reg ^ s3_reg;
endmodule
`default_nettype wire

// ### hiltmr_sticky.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// sticky status with write-one-to-clear and mask
// ****************************************
module hiltmr_sticky #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // events and software access
   input wire logic [W-1:0] evt,
   input wire logic [W-1:0] clr,
   input wire logic mask_we,
   input wire logic [W-1:0] mask_wdata,
   // state out
   output logic [W-1:0] stat,
   output logic [W-1:0] mask,
   output logic pend
);
   logic [W-1:0] stat_reg;
   logic [W-1:0] mask_reg;

   // set wins over clear so an event in the clear cycle is kept
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         stat_reg <= '0;
      end else begin
         stat_reg <= (stat_reg & ~clr) | evt;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mask_reg <= '1;
      end else if (mask_we) begin
         mask_reg <= mask_wdata;
      end
   end

   assign stat = stat_reg;
   assign mask = mask_reg;
   assign pend = |(stat_reg & ~mask_reg);
endmodule
`default_nettype wire

// ### hiltmr_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// port-level checks
// ********
module hiltmr_checker (
   // clocks and resets
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic mon_clk,
   input wire logic mon_rst_n,
   // monitors
   input wire logic [hiltmr_pkg::ERR_W-1:0] err_evt,
   input wire logic [hiltmr_pkg::CHN_W-1:0] chn_evt,
   input wire logic [hiltmr_pkg::ASYNC_W-1:0] err_evt_async,
   // bus and interrupt
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic irq
);
   logic wr_ok;
   logic ack_hit;
   logic unmask_reg;
   logic [31:0] tmo_reg;
   logic [31:0] hi_reg;
   assign wr_ok = avs_write && !avs_waitrequest;
   assign ack_hit = wr_ok && avs_address == hiltmr_pkg::ACK_OFF
      && avs_byteenable[0] && avs_writedata[0];
   // shadows follow the bus, not the design's own registers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tmo_reg <= hiltmr_pkg::ZERO_RST;
      end else if (wr_ok && avs_address == hiltmr_pkg::TMO_OFF) begin
         tmo_reg <= avs_writedata;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         unmask_reg <= 1'b0;
      end else if (wr_ok && (avs_address == hiltmr_pkg::ERR_MASK_OFF
            || avs_address == hiltmr_pkg::CHN_MASK_OFF)) begin
         unmask_reg <= 1'b1;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !irq) begin
         hi_reg <= hiltmr_pkg::ZERO_RST;
      end else begin
         hi_reg <= hi_reg + 32'h0000_0001;
      end
   end
   default clocking dc @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   chk_wait_once: assert property ((avs_read || avs_write)
      && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
   chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer too long");
   chk_idle_wait: assert property (!(avs_read || avs_write)
      && avs_waitrequest |=> avs_waitrequest) else $error("stray answer");
   chk_unmapped_zero: assert property (avs_read && !avs_waitrequest
      && avs_address[5] |-> avs_readdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   chk_ack_drops: assert property (ack_hit && irq |=> !irq)
      else $error("irq kept after ack");
   chk_tmo_limit: assert property (irq && tmo_reg != 32'h0000_0000
      |-> hi_reg < tmo_reg) else $error("irq beyond timeout");
   chk_irq_hold: assert property ($fell(irq) |-> $past(ack_hit)
      || (tmo_reg != 32'h0000_0000
      && $past(hi_reg) + 32'h0000_0001 == tmo_reg))
      else $error("irq fell without cause");
   chk_masked_quiet: assert property (!unmask_reg |-> !irq)
      else $error("irq while all masked");
   cover property ($rose(irq));
   cover property (ack_hit && irq);
   cover property ($fell(irq) && !$past(ack_hit));
endmodule
bind hiltmr_top hiltmr_checker u_chk (.sys_clk, .rst_n, .mon_clk,
   .mon_rst_n, .err_evt, .chn_evt, .err_evt_async, .avs_address,
   .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
   .avs_readdata, .avs_waitrequest, .irq);
`default_nettype wire

// ### hiltmr_host.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// host software model, bus master
// ********
module hiltmr_host (
   // clock
   input wire logic sys_clk,
   // avalon-mm master
   output logic [5:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   initial begin
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
   end
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask
   // causes cleared before the ack, else a new request starts at once
   task automatic serve(input int n);
      repeat (n) @(posedge sys_clk);
      wr(hiltmr_pkg::ERR_STAT_OFF, 32'h0000_00FF);
      wr(hiltmr_pkg::CHN_STAT_OFF, 32'h0000_00FF);
      wr(hiltmr_pkg::ACK_OFF, 32'h0000_0001);
   endtask
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic sys_clk;
   logic rst_n;
   logic mon_clk;
   logic mon_rst_n;
   logic [hiltmr_pkg::ERR_W-1:0] err_evt;
   logic [hiltmr_pkg::CHN_W-1:0] chn_evt;
   logic [hiltmr_pkg::ASYNC_W-1:0] err_evt_async;
   logic [5:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic irq;
   int mismatches = 0;
   int compares = 0;
   int cyc = 0;
   hiltmr_top u_dut (.sys_clk, .rst_n, .err_evt, .chn_evt, .mon_clk,
      .mon_rst_n, .err_evt_async, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .irq);
   hiltmr_host u_h (.sys_clk, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // monitor clock unrelated to the bus clock
   initial begin
      mon_clk = 1'b0;
      forever #35 mon_clk = ~mon_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         wrap_up();
      end
   end
   task automatic check(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up();
      if (mismatches == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic pulse(input logic [7:0] e, input logic [7:0] c);
      err_evt <= e;
      chn_evt <= c;
      @(posedge sys_clk);
      err_evt <= 8'h00;
      chn_evt <= 8'h00;
      @(posedge sys_clk);
   endtask
   task automatic wait_irq(input logic lvl);
      int i;
      i = 0;
      while (irq !== lvl && i < 40) begin
         @(posedge sys_clk);
         i++;
      end
      check("irq", {31'h0000_0000, irq}, {31'h0000_0000, lvl});
   endtask
   // ********
   // scenarios
   // ********
   task automatic t_idle();
      logic [31:0] d;
      u_h.rd(hiltmr_pkg::LAT_OFF, d);
      check("latency", d, 32'h0000_0000);
      u_h.rd(hiltmr_pkg::CTL_STAT_OFF, d);
      check("ctl", d, 32'h0000_0002);
      u_h.wr(6'h24, 32'hFFFF_FFFF);
      u_h.rd(6'h24, d);
      check("unmapped", d, 32'h0000_0000);
   endtask
   task automatic t_sticky();
      logic [31:0] d;
      pulse(8'h04, 8'h20);
      u_h.rd(hiltmr_pkg::ERR_STAT_OFF, d);
      check("err", d, 32'h0000_0004);
      u_h.rd(hiltmr_pkg::CHN_STAT_OFF, d);
      check("chn", d, 32'h0000_0020);
      check("irq", {31'h0000_0000, irq}, 32'h0000_0000);
      u_h.wr(hiltmr_pkg::ERR_STAT_OFF, 32'h0000_0004);
      u_h.rd(hiltmr_pkg::ERR_STAT_OFF, d);
      check("err clr", d, 32'h0000_0000);
      u_h.rd(hiltmr_pkg::CHN_STAT_OFF, d);
      check("chn kept", d, 32'h0000_0020);
      u_h.wr(hiltmr_pkg::CHN_STAT_OFF, 32'h0000_00FF);
   endtask
   task automatic t_lat();
      logic [31:0] l [3];
      pulse(8'h01, 8'h00);
      u_h.wr(hiltmr_pkg::ERR_MASK_OFF, 32'h0000_00FE);
      for (int k = 0; k < 3; k++) begin
         if (k > 0) begin
            pulse(8'h01, 8'h00);
         end
         wait_irq(1'b1);
         u_h.rd(hiltmr_pkg::LAT_OFF, l[k]);
         u_h.serve(5 * k);
         wait_irq(1'b0);
      end
      check("lat first", l[0], 32'h0000_0000);
      check("lat set", {31'h0000_0000, l[1] == 32'h0000_0000}, 0);
      check("lat step", l[2] - l[1], 32'h0000_0005);
      u_h.rd(hiltmr_pkg::LAT_OFF, l[0]);
      check("lat held", l[0], l[2]);
   endtask
   task automatic t_tmo();
      logic [31:0] d;
      int n;
      u_h.wr(hiltmr_pkg::TMO_OFF, 32'h0000_0006);
      u_h.wr(hiltmr_pkg::CHN_MASK_OFF, 32'h0000_00FE);
      u_h.rd(hiltmr_pkg::TMO_OFF, d);
      check("tmo rb", d, 32'h0000_0006);
      u_h.rd(hiltmr_pkg::CHN_MASK_OFF, d);
      check("mask rb", d, 32'h0000_00FE);
      pulse(8'h00, 8'h01);
      wait_irq(1'b1);
      n = 0;
      while (irq === 1'b1 && n < 40) begin
         @(posedge sys_clk);
         n++;
      end
      check("irq width", 32'(n), 32'h0000_0006);
      repeat (4) @(posedge sys_clk);
      check("irq off", {31'h0000_0000, irq}, 32'h0000_0000);
      u_h.rd(hiltmr_pkg::CTL_STAT_OFF, d);
      check("ctl tmo", d, 32'h0000_0009);
      u_h.serve(0);
      u_h.wr(hiltmr_pkg::CTL_STAT_OFF, 32'h0000_0001);
      u_h.rd(hiltmr_pkg::CTL_STAT_OFF, d);
      check("ctl idle", d, 32'h0000_0002);
      u_h.wr(hiltmr_pkg::TMO_OFF, 32'h0000_0000);
   endtask
   task automatic t_async();
      logic [31:0] d;
      @(posedge mon_clk);
      err_evt_async <= 4'h4;
      @(posedge mon_clk);
      err_evt_async <= 4'h0;
      repeat (4) @(posedge mon_clk);
      err_evt_async <= 4'h8;
      @(posedge mon_clk);
      err_evt_async <= 4'h0;
      repeat (10) @(posedge sys_clk);
      u_h.rd(hiltmr_pkg::ERR_STAT_OFF, d);
      check("async", d, 32'h0000_000C);
   endtask
   initial begin
      rst_n = 1'b0;
      mon_rst_n = 1'b0;
      err_evt = 8'h00;
      chn_evt = 8'h00;
      err_evt_async = 4'h0;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      mon_rst_n <= 1'b1;
      @(posedge sys_clk);
      t_idle();
      t_sticky();
      t_lat();
      t_tmo();
      t_async();
      wrap_up();
   end
endmodule
`default_nettype wire
